// [design/sbsr_status_byte.v]
`timescale 1ns/1ps
// Operation
// - Instrument events latch until register reset
// - Event summary is OR of enabled bits
// - Enable registers are writable and readable
// - Power-up clears registers, queue, buffer
// - Clear-status clears event registers, error queue
// - Clear-status keeps standard event enable
// - Power-on clear flag gates enable clearing; code gates only standard event enable, service enable always clears
// - Writing zero clears an enable register
// - Event registers and status byte read-only
// - Queries return binary weighted register value
// - Reading standard event register clears it
// - Status bits two to five mirror sources
// - Bit two flags pending error
// - Bit three is questionable summary
// - Bit five is standard event summary
// - Bit four flags output buffer occupancy
// - Responses leave buffer as host reads
// - Nonempty error queue asserts its summary
// - Request bit is OR of enabled summaries
// - Status byte and enable are 8 bits
// - Service enable clears at power, zero write
// - Serial poll clears request, summary persists
// - Rising enabled summary raises service request
// - Clear-status leaves service enable untouched
`include "sbsr_regs.vh"

module sbsr_status_byte #(
  parameter ESR_WIDTH = 8,
  parameter QDR_WIDTH = 16,
  parameter EQ_DEPTH  = 8,
  parameter OB_DEPTH  = 8
) (
  // Clock, reset, enable
  input  wire                 i_clock,
  input  wire                 i_sys_rst,
  input  wire                 i_clk_en,
  // Power-up indication: high for a power-on reset, low for a plain reset
  input  wire                 i_power_up,
  // Instrument event sources, one-cycle pulses per bit
  input  wire [ESR_WIDTH-1:0] i_std_event,
  input  wire [QDR_WIDTH-1:0] i_quest_event,
  input  wire                 i_error_push,
  input  wire                 i_error_pop,
  input  wire                 i_response_push,
  input  wire                 i_response_pop,
  // Command interpreter port
  input  wire                 i_cmd_write,
  input  wire                 i_cmd_read,
  input  wire [2:0]           i_cmd_sel,
  input  wire [15:0]          i_cmd_wdata,
  input  wire                 i_clear_status_command,
  input  wire                 i_status_preset,
  input  wire                 i_serial_poll,
  // Read data and status
  output reg  [15:0]          o_cmd_rdata,
  output reg                  o_cmd_rvalid,
  output reg  [7:0]           o_service_status_byte,
  output reg  [7:0]           o_serial_poll_byte,
  output reg                  o_service_request,
  output reg                  o_error_queue_full,
  output reg                  o_output_buffer_full
);

  ////////////////////////////////////////////////////////////////////////////////
  localparam EQ_CW = $clog2(EQ_DEPTH + 1);
  localparam OB_CW = $clog2(OB_DEPTH + 1);

  reg  [ESR_WIDTH-1:0] std_event_reg;
  reg  [ESR_WIDTH-1:0] std_event_next;
  reg  [ESR_WIDTH-1:0] std_enable_reg;
  reg  [QDR_WIDTH-1:0] quest_event_reg;
  reg  [QDR_WIDTH-1:0] quest_event_next;
  reg  [QDR_WIDTH-1:0] quest_enable_reg;
  reg  [7:0]           srq_enable_reg;
  reg                  psc_flag_reg;
  reg  [EQ_CW-1:0]     eq_count_reg;
  reg  [EQ_CW-1:0]     eq_count_next;
  reg  [OB_CW-1:0]     ob_count_reg;
  reg  [OB_CW-1:0]     ob_count_next;
  reg                  rqs_reg;
  reg                  mss_prev_reg;
  reg  [7:0]           stb_next;
  reg                  mss_next;

  wire wr_sre = i_cmd_write && (i_cmd_sel == `SBSR_SEL_SRE);
  wire wr_ese = i_cmd_write && (i_cmd_sel == `SBSR_SEL_ESE);
  wire wr_qde = i_cmd_write && (i_cmd_sel == `SBSR_SEL_QDE);
  wire wr_psc = i_cmd_write && (i_cmd_sel == `SBSR_SEL_PSC);
  wire rd_esr = i_cmd_read && (i_cmd_sel == `SBSR_SEL_ESR);
  wire rd_qdr = i_cmd_read && (i_cmd_sel == `SBSR_SEL_QDR);

  ////////////////////////////////////////////////////////////////////////////////
  // Event latches: a new event in the cycle of a clear still lands, so set wins.
  genvar gi;
  generate
    for (gi = 0; gi < ESR_WIDTH; gi = gi + 1)
    begin : g_esr
      always @*
      begin
        std_event_next[gi] = std_event_reg[gi];
        if (i_clear_status_command || rd_esr)
          std_event_next[gi] = 1'b0;
        if (i_std_event[gi])
          std_event_next[gi] = 1'b1;
      end
    end
    for (gi = 0; gi < QDR_WIDTH; gi = gi + 1)
    begin : g_qdr
      always @*
      begin
        quest_event_next[gi] = quest_event_reg[gi];
        if (i_clear_status_command || rd_qdr)
          quest_event_next[gi] = 1'b0;
        if (i_quest_event[gi])
          quest_event_next[gi] = 1'b1;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Queue occupancy counters. The entries themselves live in the interpreter.
  always @*
  begin
    eq_count_next = eq_count_reg;
    if (i_clear_status_command)
      eq_count_next = {EQ_CW{1'b0}};
    else if (i_error_push && !i_error_pop && (eq_count_reg != EQ_DEPTH[EQ_CW-1:0]))
      eq_count_next = eq_count_reg + 1'b1;
    else if (i_error_pop && !i_error_push && (eq_count_reg != {EQ_CW{1'b0}}))
      eq_count_next = eq_count_reg - 1'b1;
    ob_count_next = ob_count_reg;
    if (i_response_push && !i_response_pop && (ob_count_reg != OB_DEPTH[OB_CW-1:0]))
      ob_count_next = ob_count_reg + 1'b1;
    else if (i_response_pop && !i_response_push && (ob_count_reg != {OB_CW{1'b0}}))
      ob_count_next = ob_count_reg - 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status byte from the next-state values so outputs follow events in one clock.
  always @*
  begin
    stb_next = `SBSR_RESET_BYTE;
    stb_next[`SBSR_BIT_EAV_POS] = (eq_count_next != {EQ_CW{1'b0}});
    stb_next[`SBSR_BIT_QSB_POS] = |(quest_event_next & quest_enable_reg);
    stb_next[`SBSR_BIT_MAV_POS] = (ob_count_next != {OB_CW{1'b0}});
    stb_next[`SBSR_BIT_ESB_POS] = |(std_event_next & std_enable_reg);
    mss_next = |(stb_next & srq_enable_reg & `SBSR_SUMMARY_MASK);
    stb_next[`SBSR_BIT_RQS_POS] = mss_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      std_event_reg         <= {ESR_WIDTH{1'b0}};
      quest_event_reg       <= {QDR_WIDTH{1'b0}};
      eq_count_reg          <= {EQ_CW{1'b0}};
      ob_count_reg          <= {OB_CW{1'b0}};
      quest_enable_reg      <= {QDR_WIDTH{1'b0}};
      srq_enable_reg        <= `SBSR_RESET_BYTE;
      rqs_reg               <= 1'b0;
      mss_prev_reg          <= 1'b0;
      o_cmd_rdata           <= `SBSR_RESET_WORD;
      o_cmd_rvalid          <= 1'b0;
      o_service_status_byte <= `SBSR_RESET_BYTE;
      o_serial_poll_byte    <= `SBSR_RESET_BYTE;
      o_service_request     <= 1'b0;
      o_error_queue_full    <= 1'b0;
      o_output_buffer_full  <= 1'b0;
    end
    else if (i_clk_en)
    begin
      std_event_reg   <= std_event_next;
      quest_event_reg <= quest_event_next;
      eq_count_reg    <= eq_count_next;
      ob_count_reg    <= ob_count_next;
      mss_prev_reg    <= mss_next;
      // Only enable registers and the power-on clear flag accept writes; all else ignores them.
      if (wr_sre)
        srq_enable_reg <= i_cmd_wdata[7:0] & `SBSR_SUMMARY_MASK;
      if (wr_qde)
        quest_enable_reg <= i_cmd_wdata[QDR_WIDTH-1:0];
      else if (i_status_preset)
        quest_enable_reg <= {QDR_WIDTH{1'b0}};
      // A fresh rising edge beats a poll in the same cycle so no request is lost.
      if (mss_next && !mss_prev_reg)
        rqs_reg <= 1'b1;
      else if (i_serial_poll || !mss_next)
        rqs_reg <= 1'b0;
      o_service_status_byte <= stb_next;
      o_service_request     <= (mss_next && !mss_prev_reg) || (rqs_reg && mss_next && !i_serial_poll);
      if (i_serial_poll)
        o_serial_poll_byte <= {1'b0, rqs_reg || (mss_next && !mss_prev_reg), o_service_status_byte[5:0]};
      o_error_queue_full   <= (eq_count_next == EQ_DEPTH[EQ_CW-1:0]);
      o_output_buffer_full <= (ob_count_next == OB_DEPTH[OB_CW-1:0]);
      o_cmd_rvalid         <= i_cmd_read;
      if (i_cmd_read)
      begin
        o_cmd_rdata <= `SBSR_RESET_WORD;
        case (i_cmd_sel)
          `SBSR_SEL_STB: o_cmd_rdata[7:0] <= o_service_status_byte;
          `SBSR_SEL_SRE: o_cmd_rdata[7:0] <= srq_enable_reg;
          `SBSR_SEL_ESR: o_cmd_rdata[ESR_WIDTH-1:0] <= std_event_reg;
          `SBSR_SEL_ESE: o_cmd_rdata[ESR_WIDTH-1:0] <= std_enable_reg;
          `SBSR_SEL_QDR: o_cmd_rdata[QDR_WIDTH-1:0] <= quest_event_reg;
          `SBSR_SEL_QDE: o_cmd_rdata[QDR_WIDTH-1:0] <= quest_enable_reg;
          `SBSR_SEL_PSC: o_cmd_rdata[0] <= psc_flag_reg;
          default:       o_cmd_rdata <= `SBSR_RESET_WORD;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Standard event enable survives a reset unless it is a power-up with the flag
  // set; this models nonvolatile storage, so the flag itself is never reset and takes
  // its value only from initialisation and writes.
  always @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      if (i_power_up && psc_flag_reg)
        std_enable_reg <= {ESR_WIDTH{1'b0}};
    end
    else if (i_clk_en)
    begin
      if (wr_ese)
        std_enable_reg <= i_cmd_wdata[ESR_WIDTH-1:0];
      if (wr_psc)
        psc_flag_reg <= i_cmd_wdata[0];
    end
  end

  initial
  begin
    psc_flag_reg   = `SBSR_RESET_PSC;
    std_enable_reg = {ESR_WIDTH{1'b0}};
  end

endmodule // sbsr_status_byte

// [pkg/sbsr_regs.vh]
`ifndef SBSR_REGS_VH
`define SBSR_REGS_VH
// Register select codes on the command port.
`define SBSR_SEL_STB        3'h0
`define SBSR_SEL_SRE        3'h1
`define SBSR_SEL_ESR        3'h2
`define SBSR_SEL_ESE        3'h3
`define SBSR_SEL_QDR        3'h4
`define SBSR_SEL_QDE        3'h5
`define SBSR_SEL_PSC        3'h6
// Status byte field positions.
`define SBSR_BIT_EAV_POS    2
`define SBSR_BIT_QSB_POS    3
`define SBSR_BIT_MAV_POS    4
`define SBSR_BIT_ESB_POS    5
`define SBSR_BIT_RQS_POS    6
// Mask of summary bits two through five.
`define SBSR_SUMMARY_MASK   8'h3c
// Reset values.
`define SBSR_RESET_BYTE     8'h00
`define SBSR_RESET_WORD     16'h0000
`define SBSR_RESET_PSC      1'b1
`endif

// [tb/sbsr_props.sv]
`timescale 1ns/1ps
module sbsr_props (
  input wire       i_clock,
  input wire       i_sys_rst,
  input wire       i_clk_en,
  input wire       i_error_push,
  input wire       i_response_push,
  input wire       i_cmd_read,
  input wire       i_serial_poll,
  input wire       i_clear_status_command,
  input wire       o_cmd_rvalid,
  input wire [7:0] o_service_status_byte,
  input wire [7:0] o_serial_poll_byte
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // Flags get up to two edges, though the byte is registered from the next counter values in the same edge.
  chk_unused_bits: assert property (o_service_status_byte[7] == 1'b0 && o_service_status_byte[1:0] == 2'b00)
    else $error("unused status bit set");
  chk_error_flag: assert property (i_clk_en && i_error_push |-> ##[1:2] o_service_status_byte[2])
    else $error("error flag missing");
  chk_message_flag: assert property (i_clk_en && i_response_push |-> ##[1:2] o_service_status_byte[4])
    else $error("message flag missing");
  chk_clear_errors: assert property (i_clear_status_command && !i_error_push |-> ##[1:2] !o_service_status_byte[2])
    else $error("error flag kept after clear");
  chk_read_answer: assert property (i_clk_en && i_cmd_read |=> o_cmd_rvalid)
    else $error("read not answered");
  chk_answer_cause: assert property (o_cmd_rvalid |-> $past(i_cmd_read))
    else $error("answer without read");
  chk_poll_copy: assert property (i_clk_en && i_serial_poll |=> o_serial_poll_byte[5:0] == $past(o_service_status_byte[5:0]))
    else $error("poll byte differs from status");
  chk_summary_need: assert property (o_service_status_byte[6] |-> o_service_status_byte[5:2] != 4'h0)
    else $error("master summary without source");
endmodule // sbsr_props

bind sbsr_status_byte sbsr_props u_props (.i_clock, .i_sys_rst, .i_clk_en, .i_error_push, .i_response_push,
  .i_cmd_read, .i_serial_poll, .i_clear_status_command, .o_cmd_rvalid, .o_service_status_byte, .o_serial_poll_byte);

// [tb/sbsr_bus_ctrl.sv]
`timescale 1ns/1ps
// Remote controller: polls after i_wait+1 edges of request, so both prompt and slow answers are exercised.
module sbsr_bus_ctrl (
  input  wire       i_clock,
  input  wire       i_service_request,
  input  wire [3:0] i_wait,
  output reg        o_serial_poll
);
  reg [3:0] cnt_reg = 4'h0;
  initial o_serial_poll = 1'b0;
  always @(posedge i_clock)
  begin
    o_serial_poll <= 1'b0;
    if (i_service_request && !o_serial_poll)
    begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg >= i_wait)
      begin
        o_serial_poll <= 1'b1;
        cnt_reg <= 4'h0;
      end
    end
  end
endmodule // sbsr_bus_ctrl

// [tb/status_byte_service_request_tb_top.sv]
`timescale 1ns/1ps
`include "sbsr_regs.vh"
module status_byte_service_request_tb_top;
  logic        i_clock = 1'b0, i_sys_rst = 1'b1, i_power_up = 1'b1, i_cmd_write = 1'b0, i_cmd_read = 1'b0;
  logic        i_error_push = 1'b0, i_error_pop = 1'b0, i_response_push = 1'b0, i_response_pop = 1'b0;
  logic        i_clear_status_command = 1'b0, i_status_preset = 1'b0, i_clk_en = 1'b1;
  logic [7:0]  i_std_event = 8'h00;
  logic [15:0] i_quest_event = 16'h0000, i_cmd_wdata = 16'h0000, r, exp_q[$];
  logic [2:0]  i_cmd_sel = 3'h0;
  logic [3:0]  poll_wait = 4'h3;
  wire         i_serial_poll, o_cmd_rvalid, o_service_request, o_error_queue_full, o_output_buffer_full;
  wire  [15:0] o_cmd_rdata;
  wire  [7:0]  o_service_status_byte, o_serial_poll_byte;
  int          failures = 0, cmp_count = 0;
  sbsr_status_byte u_dut (.i_clock, .i_sys_rst, .i_clk_en, .i_power_up, .i_std_event, .i_quest_event,
    .i_error_push, .i_error_pop, .i_response_push, .i_response_pop, .i_cmd_write, .i_cmd_read, .i_cmd_sel,
    .i_cmd_wdata, .i_clear_status_command, .i_status_preset, .i_serial_poll, .o_cmd_rdata, .o_cmd_rvalid,
    .o_service_status_byte, .o_serial_poll_byte, .o_service_request, .o_error_queue_full, .o_output_buffer_full);
  sbsr_bus_ctrl u_ctrl (.i_clock, .i_service_request(o_service_request), .i_wait(poll_wait), .o_serial_poll(i_serial_poll));
  initial forever #50 i_clock = ~i_clock;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge i_clock);
    i_cmd_write <= 1'b1;
    i_cmd_sel <= s;
    i_cmd_wdata <= d;
    @(posedge i_clock);
    i_cmd_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] s, input logic [15:0] e);
    @(posedge i_clock);
    i_cmd_read <= 1'b1;
    i_cmd_sel <= s;
    exp_q.push_back(e);
    @(posedge i_clock);
    i_cmd_read <= 1'b0;
  endtask
  // Sampling at the falling edge keeps the compare clear of the register updates.
  task automatic sb(input int n, input logic [7:0] e, input logic q);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
    chk("status_byte", {8'h00, e}, {8'h00, o_service_status_byte});
    chk("service_request", {15'h0000, q}, {15'h0000, o_service_request});
  endtask
  task automatic rst();
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    repeat (8) @(posedge i_clock);
    i_sys_rst <= 1'b0;
  endtask
  task automatic stop_test();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_clock)
    if (o_cmd_rvalid === 1'b1)
      chk("read_data", exp_q.pop_front(), o_cmd_rdata);
  initial
  begin
    repeat (3000) @(posedge i_clock);
    failures++;
    stop_test();
  end
  initial
  begin
    r = 16'($urandom(42510));
    rst();
    rd(`SBSR_SEL_SRE, 16'h0000);
    rd(`SBSR_SEL_ESE, 16'h0000);
    r = 16'($urandom);
    wr(`SBSR_SEL_SRE, r);
    rd(`SBSR_SEL_SRE, r & 16'h003c);
    wr(`SBSR_SEL_QDE, r);
    rd(`SBSR_SEL_QDE, r);
    wr(`SBSR_SEL_ESR, 16'hffff);
    wr(`SBSR_SEL_STB, 16'hffff);
    rd(`SBSR_SEL_ESR, 16'h0000);
    rd(3'h7, 16'h0000);
    wr(`SBSR_SEL_ESE, 16'h0024);
    wr(`SBSR_SEL_PSC, 16'h0000);
    rst();
    rd(`SBSR_SEL_ESE, 16'h0024);
    rd(`SBSR_SEL_SRE, 16'h0000);
    wr(`SBSR_SEL_PSC, 16'h0001);
    rst();
    rd(`SBSR_SEL_ESE, 16'h0000);
    wr(`SBSR_SEL_ESE, 16'h00ff);
    wr(`SBSR_SEL_SRE, 16'h0020);
    r = {8'h00, 8'($urandom) | 8'h01};
    @(posedge i_clock) i_std_event <= r[7:0];
    @(posedge i_clock) i_std_event <= 8'h00;
    sb(1, 8'h60, 1'b1);
    sb(6, 8'h60, 1'b0);
    rd(`SBSR_SEL_ESR, r);
    sb(2, 8'h00, 1'b0);
    poll_wait <= 4'h0;
    wr(`SBSR_SEL_QDE, 16'h8001);
    wr(`SBSR_SEL_SRE, 16'h0008);
    @(posedge i_clock) i_quest_event <= 16'h8000;
    @(posedge i_clock) i_quest_event <= 16'h0000;
    sb(4, 8'h48, 1'b0);
    chk("serial_poll_byte", 16'h0048, {8'h00, o_serial_poll_byte});
    @(posedge i_clock) i_error_push <= 1'b1;
    i_response_push <= 1'b1;
    @(posedge i_clock) i_error_push <= 1'b0;
    i_response_push <= 1'b0;
    sb(2, 8'h5c, 1'b0);
    @(posedge i_clock) i_response_pop <= 1'b1;
    @(posedge i_clock) i_response_pop <= 1'b0;
    i_clear_status_command <= 1'b1;
    i_status_preset <= 1'b1;
    @(posedge i_clock) i_clear_status_command <= 1'b0;
    i_status_preset <= 1'b0;
    sb(2, 8'h00, 1'b0);
    rd(`SBSR_SEL_QDR, 16'h0000);
    rd(`SBSR_SEL_ESE, 16'h00ff);
    rd(`SBSR_SEL_SRE, 16'h0008);
    wr(`SBSR_SEL_SRE, 16'h0000);
    rd(`SBSR_SEL_SRE, 16'h0000);
    // Fill both queues to their depth, then drain one response and empty the error queue with clear-status.
    @(posedge i_clock) i_error_push <= 1'b1;
    i_response_push <= 1'b1;
    repeat (8) @(posedge i_clock);
    i_error_push <= 1'b0;
    i_response_push <= 1'b0;
    @(negedge i_clock);
    chk("error_queue_full", 16'h0001, {15'h0000, o_error_queue_full});
    chk("output_buffer_full", 16'h0001, {15'h0000, o_output_buffer_full});
    @(posedge i_clock) i_response_pop <= 1'b1;
    i_clear_status_command <= 1'b1;
    @(posedge i_clock) i_response_pop <= 1'b0;
    i_clear_status_command <= 1'b0;
    @(negedge i_clock);
    chk("error_queue_full", 16'h0000, {15'h0000, o_error_queue_full});
    chk("output_buffer_full", 16'h0000, {15'h0000, o_output_buffer_full});
    // With the clock enable low an error push must leave the status byte alone.
    @(posedge i_clock) i_clk_en <= 1'b0;
    i_error_push <= 1'b1;
    sb(2, 8'h10, 1'b0);
    @(posedge i_clock) i_clk_en <= 1'b1;
    i_error_push <= 1'b0;
    repeat (4) @(posedge i_clock);
    stop_test();
  end
endmodule // status_byte_service_request_tb_top
